/* File: include/ulsn_pkg.sv */
/*
  Package for the host-side USB 2.0 line controller: line states, speeds,
  packed carriers and every count of cycles.
  Assumes a 10 MHz system clock; line pins are sampled synchronously.
*/
// What this block does
// - both lines low decode as single-ended zero and both high as single-ended one at every speed.
// - low speed J is D+ low D- high, full/high speed J is D+ high D- low, K is the opposite.
// - neither party drives both lines high except in passing; a lasting single-ended one is abnormal.
// - bits are NRZI coded, a 1 keeps the line state and a 0 toggles between J and K.
// - after six consecutive 1 bits the transmitter inserts a 0 bit.
// - the receiver realigns its sampling phase on every valid line transition.
// - the port classifies full speed when D+ idles high and low speed when D- idles high.
// - a full-speed host serves both full and low speed devices; a device needs only its own speed.
// - after a full-speed attach the host drives reset and watches for a chirp K, else stays full speed.
// - on seeing the device chirp K the host answers with alternating chirp K and chirp J pairs.
// - before the dual-simplex channel is used termination is checked; if absent the host falls back.
// - with termination found the link is trained, and only then enters U0 and carries data; here U0 only sets status.ss_u0 and no data path uses it.
package ulsn_pkg;

  typedef enum logic [1:0] {ULSN_SE0, ULSN_J, ULSN_K, ULSN_SE1} ulsn_line_type;
  typedef enum logic [1:0] {ULSN_SPD_NONE, ULSN_SPD_LOW, ULSN_SPD_FULL, ULSN_SPD_HIGH} ulsn_speed_type;

  // times in their own units and derived cycle counts at 10 MHz
  localparam int ULSN_CLK_NS = 100;
  localparam int ULSN_BIT_CYC = 4;           // system cycles per line bit
  localparam int ULSN_ATTACH_US = 100;       // idle level must hold this long
  localparam int ULSN_RESET_US = 10000;      // bus reset length
  localparam int ULSN_CHIRP_WAIT_US = 7000;  // watch window for chirp K
  localparam int ULSN_CHIRP_US = 50;         // one host chirp
  localparam int ULSN_SE1_US = 1;            // lasting SE1 limit
  localparam int ULSN_TRAIN_US = 20;         // link training length
  localparam int ULSN_ATTACH_CYC = ULSN_ATTACH_US * 1000 / ULSN_CLK_NS;
  localparam int ULSN_RESET_CYC = ULSN_RESET_US * 1000 / ULSN_CLK_NS;
  localparam int ULSN_CHIRP_WAIT_CYC = ULSN_CHIRP_WAIT_US * 1000 / ULSN_CLK_NS;
  localparam int ULSN_CHIRP_CYC = ULSN_CHIRP_US * 1000 / ULSN_CLK_NS;
  localparam int ULSN_SE1_CYC = ULSN_SE1_US * 1000 / ULSN_CLK_NS;
  localparam int ULSN_TRAIN_CYC = ULSN_TRAIN_US * 1000 / ULSN_CLK_NS;
  localparam int ULSN_CHIRP_PAIRS = 3;
  localparam int ULSN_STUFF_RUN = 6;
  localparam int ULSN_CNT_W = 20;

  // line pins as two signals each
  typedef struct packed {
    logic dp_o;
    logic dp_oe_n;
    logic dm_o;
    logic dm_oe_n;
  } ulsn_pins_out_type;

  // status toward the user side
  typedef struct packed {
    ulsn_speed_type speed;
    logic attached;
    logic se1_err;
    logic ss_u0;
    logic ss_fallback;
  } ulsn_status_type;

endpackage

/* File: rtl/ulsn_bit_rx.sv */
/*
  Receive bit path: NRZI decode, phase realign on transitions and stuff
  bit removal. Assumes line state already decoded and synchronous to clk.
*/
`timescale 1ns/1ps
module ulsn_bit_rx (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // line side
  input wire logic en,
  input wire ulsn_pkg::ulsn_line_type line,
  // user side
  output logic bit_valid,
  output logic bit_data,
  output logic stuff_err
);

  typedef struct packed {
    logic [1:0] phase;
    ulsn_pkg::ulsn_line_type prev;
    ulsn_pkg::ulsn_line_type last_bit;
    logic [2:0] ones;
    logic valid;
    logic data;
    logic err;
  } ulsn_rx_state_type;

  ulsn_rx_state_type s_q, s_d;
  logic is_bit;

  // sample mid-bit; realign on every J/K change, drop stuffed zeros
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.err = 1'b0;
    is_bit = 1'b0;
    s_d.prev = line;
    if (!en) begin
      s_d.phase = 2'h0;
      s_d.ones = 3'h0;
    end else begin
      if (line != s_q.prev && (line == ulsn_pkg::ULSN_J || line == ulsn_pkg::ULSN_K)) begin
        s_d.phase = 2'h0;
      end else begin
        s_d.phase = s_q.phase + 2'h1;
      end
      is_bit = (s_d.phase == 2'(ulsn_pkg::ULSN_BIT_CYC / 2)) &&
               (line == ulsn_pkg::ULSN_J || line == ulsn_pkg::ULSN_K);
      if (is_bit) begin
        s_d.last_bit = line;
        if (line == s_q.last_bit) begin
          if (s_q.ones == 3'(ulsn_pkg::ULSN_STUFF_RUN)) begin
            s_d.err = 1'b1;
            s_d.ones = 3'h0;
          end else begin
            s_d.ones = s_q.ones + 3'h1;
            s_d.valid = 1'b1;
            s_d.data = 1'b1;
          end
        end else begin
          s_d.ones = 3'h0;
          if (s_q.ones != 3'(ulsn_pkg::ULSN_STUFF_RUN)) begin
            s_d.valid = 1'b1;
            s_d.data = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{phase: 2'h0, prev: ulsn_pkg::ULSN_SE0, last_bit: ulsn_pkg::ULSN_J,
               ones: 3'h0, valid: 1'b0, data: 1'b0, err: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_valid = s_q.valid;
  assign bit_data = s_q.data;
  assign stuff_err = s_q.err;

  // a stuffed zero after six ones never reaches the user
  a_stuff_drop: assert property (@(posedge clk) disable iff (sys_rst)
    (is_bit && s_q.ones == 3'h6 && line != s_q.last_bit) |=> !bit_valid)
    else $error("stuffed zero passed upward");
  // phase restarts on a J/K edge
  a_phase_align: assert property (@(posedge clk) disable iff (sys_rst)
    (en && line != s_q.prev && line != ulsn_pkg::ULSN_SE0 && line != ulsn_pkg::ULSN_SE1)
    |=> s_q.phase == 2'h0)
    else $error("phase not realigned");

endmodule

/* File: rtl/ulsn_host_ctrl.sv */
/*
  Host-side USB 2.0 port line controller: attach and speed detection,
  bus reset with chirp handshake, NRZI transmit with stuffing, receive
  through ulsn_bit_rx, and the dual-simplex termination/training gate.
  Assumes pins and termination sense are synchronous to clk.
*/
`timescale 1ns/1ps
module ulsn_host_ctrl #(
  parameter int ATTACH_CYC = ulsn_pkg::ULSN_ATTACH_CYC,
  parameter int RESET_CYC = ulsn_pkg::ULSN_RESET_CYC,
  parameter int CHIRP_WAIT_CYC = ulsn_pkg::ULSN_CHIRP_WAIT_CYC,
  parameter int CHIRP_CYC = ulsn_pkg::ULSN_CHIRP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // data line pins
  input wire logic dp_i,
  input wire logic dm_i,
  output ulsn_pkg::ulsn_pins_out_type pins,
  // dual-simplex channel
  input wire logic term_det,
  output logic term_probe,
  output logic train_active,
  // transmit bit stream
  input wire logic tx_valid,
  input wire logic tx_data,
  output logic tx_ready,
  // receive bit stream
  output logic rx_valid,
  output logic rx_data,
  output logic rx_stuff_err,
  // status
  input wire logic hs_enable,
  output ulsn_pkg::ulsn_status_type status
);

  typedef enum logic [3:0] {
    ST_DETACHED, ST_RESET, ST_CHIRP_WAIT, ST_CHIRP_K, ST_CHIRP_J, ST_RUN, ST_TX
  } ulsn_st_type;

  typedef enum logic [1:0] {SS_DETECT, SS_TRAIN, SS_U0, SS_OFF} ulsn_ss_type;

  typedef struct packed {
    ulsn_st_type st;
    ulsn_ss_type ss;
    logic [ulsn_pkg::ULSN_CNT_W-1:0] cnt;
    logic [ulsn_pkg::ULSN_CNT_W-1:0] ss_cnt;
    logic [ulsn_pkg::ULSN_CNT_W-1:0] se1_cnt;
    logic [2:0] pairs;
    logic [1:0] bphase;
    logic [2:0] ones;
    logic stuffing;
    ulsn_pkg::ulsn_line_type txline;
    ulsn_pkg::ulsn_pins_out_type pins;
    ulsn_pkg::ulsn_status_type status;
    logic ready;
    logic probe;
    logic train;
  } ulsn_host_state_type;

  ulsn_host_state_type s_q, s_d;
  ulsn_pkg::ulsn_line_type line;
  logic raw_dev_chirp_k;

  // decode the pins into a line state for the current speed
  always_comb begin
    case ({dp_i, dm_i})
      2'b00: line = ulsn_pkg::ULSN_SE0;
      2'b11: line = ulsn_pkg::ULSN_SE1;
      2'b01: line = (s_q.status.speed == ulsn_pkg::ULSN_SPD_LOW) ? ulsn_pkg::ULSN_J : ulsn_pkg::ULSN_K;
      default: line = (s_q.status.speed == ulsn_pkg::ULSN_SPD_LOW) ? ulsn_pkg::ULSN_K : ulsn_pkg::ULSN_J;
    endcase
  end

  // device chirp K is D- high after reset at full-speed naming
  assign raw_dev_chirp_k = !dp_i && dm_i;

  // pins for a line state at the current speed; SE1 is never produced
  function automatic ulsn_pkg::ulsn_pins_out_type drive(input ulsn_pkg::ulsn_line_type l,
                                                       input logic low);
    ulsn_pkg::ulsn_pins_out_type p;
    p.dp_oe_n = 1'b0;
    p.dm_oe_n = 1'b0;
    case (l)
      ulsn_pkg::ULSN_J: begin
        p.dp_o = !low;
        p.dm_o = low;
      end
      ulsn_pkg::ULSN_K: begin
        p.dp_o = low;
        p.dm_o = !low;
      end
      default: begin
        p.dp_o = 1'b0;
        p.dm_o = 1'b0;
      end
    endcase
    return p;
  endfunction

  localparam ulsn_pkg::ulsn_pins_out_type PINS_REL = '{dp_o: 1'b0, dp_oe_n: 1'b1, dm_o: 1'b0, dm_oe_n: 1'b1};

  // main sequencing
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 1'b1;
    s_d.ready = 1'b0;
    // lasting SE1 is flagged as abnormal
    if (line == ulsn_pkg::ULSN_SE1 && s_q.pins.dp_oe_n) begin
      s_d.se1_cnt = s_q.se1_cnt + 1'b1;
    end else begin
      s_d.se1_cnt = '0;
    end
    s_d.status.se1_err = (s_q.se1_cnt >= ulsn_pkg::ULSN_CNT_W'(ulsn_pkg::ULSN_SE1_CYC));
    case (s_q.st)
      ST_DETACHED: begin
        s_d.pins = PINS_REL;
        s_d.status.attached = 1'b0;
        s_d.status.speed = ulsn_pkg::ULSN_SPD_NONE;
        if (dp_i == dm_i) begin
          s_d.cnt = '0;
        end else if (s_q.cnt == ulsn_pkg::ULSN_CNT_W'(ATTACH_CYC)) begin
          s_d.status.attached = 1'b1;
          // either speed is accepted on this port
          s_d.status.speed = dp_i ? ulsn_pkg::ULSN_SPD_FULL : ulsn_pkg::ULSN_SPD_LOW;
          s_d.st = ST_RESET;
          s_d.cnt = '0;
        end
      end
      ST_RESET: begin
        s_d.pins = drive(ulsn_pkg::ULSN_SE0, 1'b0);
        if (s_q.cnt == ulsn_pkg::ULSN_CNT_W'(RESET_CYC)) begin
          s_d.pins = PINS_REL;
          s_d.cnt = '0;
          s_d.st = (hs_enable && s_q.status.speed == ulsn_pkg::ULSN_SPD_FULL) ? ST_CHIRP_WAIT : ST_RUN;
        end
      end
      ST_CHIRP_WAIT: begin
        if (raw_dev_chirp_k) begin
          s_d.st = ST_CHIRP_K;
          s_d.cnt = '0;
          s_d.pairs = '0;
        end else if (s_q.cnt == ulsn_pkg::ULSN_CNT_W'(CHIRP_WAIT_CYC)) begin
          s_d.st = ST_RUN; // no chirp K: stay full speed
        end
      end
      ST_CHIRP_K: begin
        s_d.pins = '{dp_o: 1'b0, dp_oe_n: 1'b0, dm_o: 1'b1, dm_oe_n: 1'b0};
        if (s_q.cnt == ulsn_pkg::ULSN_CNT_W'(CHIRP_CYC)) begin
          s_d.st = ST_CHIRP_J;
          s_d.cnt = '0;
        end
      end
      ST_CHIRP_J: begin
        s_d.pins = '{dp_o: 1'b1, dp_oe_n: 1'b0, dm_o: 1'b0, dm_oe_n: 1'b0};
        if (s_q.cnt == ulsn_pkg::ULSN_CNT_W'(CHIRP_CYC)) begin
          s_d.cnt = '0;
          s_d.pairs = s_q.pairs + 3'h1;
          if (s_q.pairs == 3'(ulsn_pkg::ULSN_CHIRP_PAIRS - 1)) begin
            // device releases its pull-up on seeing the pairs
            s_d.status.speed = ulsn_pkg::ULSN_SPD_HIGH;
            s_d.st = ST_RUN;
            s_d.pins = PINS_REL;
          end else begin
            s_d.st = ST_CHIRP_K;
          end
        end
      end
      ST_RUN: begin
        s_d.pins = PINS_REL;
        s_d.txline = ulsn_pkg::ULSN_J;
        s_d.ones = '0;
        s_d.bphase = '0;
        if (s_q.status.speed != ulsn_pkg::ULSN_SPD_HIGH && line == ulsn_pkg::ULSN_SE0 &&
            s_q.se1_cnt == '0 && dp_i == 1'b0 && dm_i == 1'b0 && s_q.cnt == ulsn_pkg::ULSN_CNT_W'(ATTACH_CYC)) begin
          s_d.st = ST_DETACHED; // long SE0 while idle: device gone
          s_d.cnt = '0;
        end else if (line != ulsn_pkg::ULSN_SE0) begin
          s_d.cnt = '0;
        end
        if (tx_valid) begin
          s_d.st = ST_TX;
          s_d.ready = 1'b1;
          s_d.pins = drive(tx_data ? ulsn_pkg::ULSN_J : ulsn_pkg::ULSN_K,
                           s_q.status.speed == ulsn_pkg::ULSN_SPD_LOW);
          s_d.txline = tx_data ? ulsn_pkg::ULSN_J : ulsn_pkg::ULSN_K;
          s_d.ones = tx_data ? 3'h1 : 3'h0;
          s_d.cnt = '0;
        end
      end
      ST_TX: begin
        s_d.bphase = s_q.bphase + 2'h1;
        if (s_q.bphase == 2'(ulsn_pkg::ULSN_BIT_CYC - 1)) begin
          if (s_q.ones == 3'(ulsn_pkg::ULSN_STUFF_RUN)) begin
            // forced transition, data bit waits
            s_d.txline = (s_q.txline == ulsn_pkg::ULSN_J) ? ulsn_pkg::ULSN_K : ulsn_pkg::ULSN_J;
            s_d.ones = '0;
          end else if (tx_valid) begin
            s_d.ready = 1'b1;
            if (tx_data) begin
              s_d.ones = s_q.ones + 3'h1; // 1 holds the line
            end else begin
              s_d.txline = (s_q.txline == ulsn_pkg::ULSN_J) ? ulsn_pkg::ULSN_K : ulsn_pkg::ULSN_J;
              s_d.ones = '0;
            end
          end else begin
            s_d.st = ST_RUN;
            s_d.pins = PINS_REL;
          end
        end
        if (s_d.st == ST_TX) begin
          s_d.pins = drive(s_d.txline, s_q.status.speed == ulsn_pkg::ULSN_SPD_LOW);
        end
      end
      default: s_d.st = ST_DETACHED;
    endcase
    s_d.stuffing = (s_q.st == ST_TX) && (s_q.bphase == 2'(ulsn_pkg::ULSN_BIT_CYC - 1)) &&
                   (s_q.ones == 3'(ulsn_pkg::ULSN_STUFF_RUN));
    // dual-simplex channel: detect, train, then U0, else fall back
    s_d.ss_cnt = s_q.ss_cnt + 1'b1;
    case (s_q.ss)
      SS_DETECT: begin
        s_d.probe = 1'b1;
        if (term_det) begin
          s_d.ss = SS_TRAIN;
          s_d.ss_cnt = '0;
          s_d.probe = 1'b0;
        end else if (s_q.ss_cnt == ulsn_pkg::ULSN_CNT_W'(ulsn_pkg::ULSN_TRAIN_CYC)) begin
          s_d.ss = SS_OFF;
          s_d.probe = 1'b0;
        end
      end
      SS_TRAIN: begin
        s_d.train = 1'b1;
        if (s_q.ss_cnt == ulsn_pkg::ULSN_CNT_W'(ulsn_pkg::ULSN_TRAIN_CYC)) begin
          s_d.ss = SS_U0;
          s_d.train = 1'b0;
        end
      end
      SS_U0: s_d.ss = SS_U0;
      SS_OFF: s_d.ss = SS_OFF;
      default: s_d.ss = SS_DETECT;
    endcase
    s_d.status.ss_u0 = (s_d.ss == SS_U0);
    s_d.status.ss_fallback = (s_d.ss == SS_OFF);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{st: ST_DETACHED, ss: SS_DETECT, cnt: '0, ss_cnt: '0, se1_cnt: '0, pairs: 3'h0,
               bphase: 2'h0, ones: 3'h0, stuffing: 1'b0, txline: ulsn_pkg::ULSN_J,
               pins: '{dp_o: 1'b0, dp_oe_n: 1'b1, dm_o: 1'b0, dm_oe_n: 1'b1},
               status: '{speed: ulsn_pkg::ULSN_SPD_NONE, attached: 1'b0, se1_err: 1'b0,
                         ss_u0: 1'b0, ss_fallback: 1'b0},
               ready: 1'b0, probe: 1'b0, train: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // receive path runs only while the host is listening
  ulsn_bit_rx u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .en(s_q.st == ST_RUN),
    .line(line),
    .bit_valid(rx_valid),
    .bit_data(rx_data),
    .stuff_err(rx_stuff_err)
  );

  assign pins = s_q.pins;
  assign status = s_q.status;
  assign tx_ready = s_q.ready;
  assign term_probe = s_q.probe;
  assign train_active = s_q.train;

  // host never drives SE1
  a_no_se1_drive: assert property (@(posedge clk) disable iff (sys_rst)
    !(pins.dp_oe_n == 1'b0 && pins.dm_oe_n == 1'b0 && pins.dp_o && pins.dm_o))
    else $error("host drove both lines high");
  // low speed J puts D- high when transmitting
  a_ls_j_level: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.st == ST_TX && s_q.status.speed == ulsn_pkg::ULSN_SPD_LOW && s_q.txline == ulsn_pkg::ULSN_J
     && !pins.dp_oe_n) |-> (!pins.dp_o && pins.dm_o))
    else $error("low speed J level wrong");
  // a stuffed bit always toggles the line
  a_stuff_toggle: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.stuffing |-> s_q.txline != $past(s_q.txline))
    else $error("stuffed bit did not toggle");
  // a sent 1 keeps the line state
  a_nrzi_one: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.st == ST_TX && s_q.bphase == 2'h3 && s_q.ones != 3'h6 && tx_valid && tx_data)
    |=> s_q.txline == $past(s_q.txline))
    else $error("logic one changed line");
  // attach speed is full when D+ idles high
  a_speed_class: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.st == ST_DETACHED && dp_i && !dm_i && s_q.cnt == ulsn_pkg::ULSN_CNT_W'(ATTACH_CYC))
    |=> status.speed == ulsn_pkg::ULSN_SPD_FULL)
    else $error("full speed not classified");
  // a full-speed host also classifies low speed
  a_low_class: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.st == ST_DETACHED && !dp_i && dm_i && s_q.cnt == ulsn_pkg::ULSN_CNT_W'(ATTACH_CYC))
    |=> status.speed == ulsn_pkg::ULSN_SPD_LOW)
    else $error("low speed not classified");
  // reset drives SE0 on both lines
  a_reset_se0: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.st == ST_RESET && $past(s_q.st) == ST_RESET) |-> (!pins.dp_o && !pins.dm_o && !pins.dp_oe_n))
    else $error("reset not SE0");
  // chirp K from device starts the host chirps
  a_chirp_answer: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.st == ST_CHIRP_WAIT && raw_dev_chirp_k) |=> ##1 (pins.dm_o && !pins.dp_o))
    else $error("no chirp answer");
  // U0 only after training
  a_u0_after_train: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(status.ss_u0) |-> $past(s_q.ss, 2) == SS_TRAIN)
    else $error("U0 without training");
  // fallback only without termination
  a_fallback: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(status.ss_fallback) |-> $past(s_q.ss, 2) == SS_DETECT && !$past(term_det, 2))
    else $error("bad fallback");

endmodule

/* File: testbench/ulsn_dev_model.sv */
/*
  Behavioural peripheral on the far side of the host port: pull-ups for
  attach, chirp K after bus reset, counting of host chirp pairs.
  Assumes host pins arrive as the package carrier; tb may override lines.
*/
`timescale 1ns/1ps
module ulsn_dev_model #(
  parameter int CHIRP_LEN = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host side pins
  input wire ulsn_pkg::ulsn_pins_out_type pins,
  // scenario controls
  input wire logic conn,
  input wire logic low_spd,
  input wire logic hs_cap,
  input wire logic ovr_en,
  input wire logic ovr_dp,
  input wire logic ovr_dm,
  // resolved lines and mode
  output logic dp_i,
  output logic dm_i,
  output logic hs_mode
);
  logic host_se0, host_j, host_k, was_k, dev_dp, dev_dm;
  int se0_cnt, chirp_cnt, pairs;

  // host line states in full speed coding
  assign host_se0 = !pins.dp_oe_n && !pins.dm_oe_n && !pins.dp_o && !pins.dm_o;
  assign host_k = !pins.dp_oe_n && !pins.dp_o && pins.dm_o;
  assign host_j = !pins.dp_oe_n && pins.dp_o && !pins.dm_o;

  // chirp after reset ends, then count host K-J pairs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      se0_cnt <= 0;
      chirp_cnt <= 0;
      pairs <= 0;
      was_k <= 1'b0;
      hs_mode <= 1'b0;
    end else begin
      se0_cnt <= host_se0 ? se0_cnt + 1 : 0;
      if (se0_cnt >= 8 && !host_se0 && hs_cap && !hs_mode) begin
        chirp_cnt <= CHIRP_LEN;
      end else if (chirp_cnt > 0) begin
        chirp_cnt <= chirp_cnt - 1;
      end
      if (host_k) begin
        was_k <= 1'b1;
      end else if (host_j && was_k) begin
        was_k <= 1'b0;
        pairs <= pairs + 1;
      end
      if (pairs >= 3 && hs_cap) begin
        hs_mode <= 1'b1;
      end
    end
  end

  // device drive: pull-ups, chirp, released lines go low
  always_comb begin
    if (ovr_en) begin
      {dev_dp, dev_dm} = {ovr_dp, ovr_dm};
    end else if (chirp_cnt > 0) begin
      {dev_dp, dev_dm} = 2'h1; // chirp K
    end else if (!conn || hs_mode) begin
      {dev_dp, dev_dm} = 2'h0; // pull-up released
    end else if (low_spd) begin
      {dev_dp, dev_dm} = 2'h1;
    end else begin
      {dev_dp, dev_dm} = 2'h2;
    end
    dp_i = pins.dp_oe_n ? dev_dp : pins.dp_o;
    dm_i = pins.dm_oe_n ? dev_dm : pins.dm_o;
  end
endmodule

/* File: testbench/test_usb_line_signaling_speed_negotiation.sv */
/*
  Self-checking bench for the host port line controller with a device model.
  Assumes short counts set through the controller parameters.
*/
`timescale 1ns/1ps
module test_usb_line_signaling_speed_negotiation;
  logic clk, sys_rst, dp_i, dm_i, term_det, term_probe, train_active, tx_valid, tx_data, tx_ready;
  logic rx_valid, rx_data, rx_stuff_err, hs_enable, conn, low_spd, hs_cap, ovr_en, ovr_dp, ovr_dm, hs_mode;
  ulsn_pkg::ulsn_pins_out_type pins;
  ulsn_pkg::ulsn_status_type status;
  int n_mismatch, check_count, cyc, k, n_serr;
  logic rxq[$];

  ulsn_host_ctrl #(.ATTACH_CYC(8), .RESET_CYC(20), .CHIRP_WAIT_CYC(40), .CHIRP_CYC(6)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .dp_i(dp_i), .dm_i(dm_i), .pins(pins), .term_det(term_det),
    .term_probe(term_probe), .train_active(train_active), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_stuff_err(rx_stuff_err),
    .hs_enable(hs_enable), .status(status));

  ulsn_dev_model i_dev (.clk(clk), .sys_rst(sys_rst), .pins(pins), .conn(conn), .low_spd(low_spd),
    .hs_cap(hs_cap), .ovr_en(ovr_en), .ovr_dp(ovr_dp), .ovr_dm(ovr_dm), .dp_i(dp_i), .dm_i(dm_i),
    .hs_mode(hs_mode));

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // cycle count, hang limit and decoded bit capture
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (rx_stuff_err === 1'b1) n_serr++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #10;
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (20) tick();
    sys_rst = 1'b0;
  endtask

  task automatic wait_attach();
    for (k = 0; k < 300 && status.attached !== 1'b1; k++) tick();
  endtask

  // send bits and check line coding, stuffing and release
  task automatic tx_bits(input logic [15:0] bits, input int n, input logic low);
    logic cur;
    int ones, last, gap, i;
    cur = 1'b1;
    ones = 0;
    last = 0;
    for (i = 0; i < n; i++) begin
      gap = 4;
      if (ones == 6) begin
        cur = ~cur;
        ones = 0;
        gap = 8;
      end
      cur = bits[i] ? cur : ~cur;
      ones = bits[i] ? ones + 1 : 0;
      tx_valid = 1'b1;
      tx_data = bits[i];
      tick();
      for (k = 0; k < 400 && tx_ready !== 1'b1; k++) tick();
      chk({14'h0, pins.dp_o, pins.dm_o}, (cur ^ low) ? 16'h2 : 16'h1);
      if (i > 0) chk(16'(cyc - last), 16'(gap));
      last = cyc;
    end
    tx_valid = 1'b0;
    repeat (20) tick();
    chk({14'h0, pins.dp_oe_n, pins.dm_oe_n}, 16'h3);
  endtask

  // no termination: fallback
  task automatic t_fallback();
    chk({15'h0, term_probe}, 16'h1);
    repeat (260) tick();
    chk({14'h0, status.ss_fallback, status.ss_u0}, 16'h2);
  endtask

  // full speed attach, reset SE0, transmit with stuffing
  task automatic t_full();
    conn = 1'b1;
    wait_attach();
    chk({13'h0, status.attached, status.speed}, {13'h0, 1'b1, ulsn_pkg::ULSN_SPD_FULL});
    for (k = 0; k < 50 && pins.dp_oe_n !== 1'b0; k++) tick();
    chk({12'h0, pins}, 16'h0);
    tx_bits(16'h02FE, 10, 1'b0);
  endtask

  // receive a stuffed frame with a stretched first bit
  task automatic t_rx();
    logic [8:0] d;
    logic lvl;
    int i, ones, serr0;
    d = 9'h0FE;
    lvl = 1'b0;
    ones = 0;
    {ovr_en, ovr_dp, ovr_dm} = 3'h6;
    repeat (8) tick();
    // one K first: idle J decodes as ones, so this restarts the receiver's run count
    {ovr_dp, ovr_dm} = 2'h1;
    repeat (4) tick();
    rxq.delete();
    serr0 = n_serr;
    for (i = 0; i < 9; i++) begin
      if (ones == 6) begin
        lvl = ~lvl;
        ones = 0;
        {ovr_dp, ovr_dm} = {lvl, ~lvl};
        repeat (4) tick();
      end
      lvl = d[i] ? lvl : ~lvl;
      ones = d[i] ? ones + 1 : 0;
      {ovr_dp, ovr_dm} = {lvl, ~lvl};
      repeat (i == 0 ? 5 : 4) tick();
    end
    chk(16'(n_serr - serr0), 16'h0);
    // a long J becomes a seventh identical bit and must be flagged
    {ovr_dp, ovr_dm} = 2'h2;
    repeat (40) tick();
    chk(16'(n_serr - serr0 > 0), 16'h1);
    ovr_en = 1'b0;
    while (rxq.size() > 0 && rxq[0] === 1'b1) void'(rxq.pop_front());
    chk(16'(rxq.size() >= 9), 16'h1);
    for (i = 0; i < 9 && i < rxq.size(); i++) chk({15'h0, rxq[i]}, {15'h0, d[i]});
  endtask

  // low speed attach and coding
  task automatic t_low();
    low_spd = 1'b1;
    do_reset();
    wait_attach();
    chk({14'h0, status.speed}, {14'h0, ulsn_pkg::ULSN_SPD_LOW});
    tx_bits(16'h0002, 3, 1'b1);
    low_spd = 1'b0;
  endtask

  // chirp handshake and dual-simplex training
  task automatic t_hs();
    {hs_cap, hs_enable, term_det} = 3'h7;
    do_reset();
    for (k = 0; k < 50 && train_active !== 1'b1; k++) tick();
    chk({14'h0, train_active, status.ss_u0}, 16'h2);
    for (k = 0; k < 400 && status.ss_u0 !== 1'b1; k++) tick();
    chk({15'h0, status.ss_u0}, 16'h1);
    for (k = 0; k < 1000 && status.speed !== ulsn_pkg::ULSN_SPD_HIGH; k++) tick();
    chk({14'h0, status.speed}, {14'h0, ulsn_pkg::ULSN_SPD_HIGH});
    chk({15'h0, hs_mode}, 16'h1);
  endtask

  // no chirp reply: full speed stays; then lasting SE1
  task automatic t_nochirp_se1();
    {hs_cap, term_det} = 2'h0;
    do_reset();
    wait_attach();
    repeat (150) tick();
    chk({13'h0, status.speed, hs_mode}, {13'h0, ulsn_pkg::ULSN_SPD_FULL, 1'b0});
    {ovr_en, ovr_dp, ovr_dm} = 3'h7;
    repeat (20) tick();
    chk({15'h0, status.se1_err}, 16'h1);
    ovr_en = 1'b0;
  endtask

  // main sequence
  initial begin
    {sys_rst, term_det, tx_valid, tx_data, hs_enable, conn, low_spd, hs_cap} = 8'h80;
    {ovr_en, ovr_dp, ovr_dm} = 3'h0;
    n_mismatch = 0;
    check_count = 0;
    cyc = 0;
    do_reset();
    tick();
    t_fallback();
    t_full();
    t_rx();
    t_low();
    t_hs();
    t_nochirp_se1();
    complete_run();
  end
endmodule
